// *** common/dsp_half_defines.svh ***
/*
 * constants for the multiply half-block front end: widths, counts,
 * reset values and loopback bit positions.
 * assumes it is included by bare name from design files only.
 */
`ifndef DSP_HALF_DEFINES_SVH
`define DSP_HALF_DEFINES_SVH

`define OPW          18
`define PRODW        36
`define SUMW         37
`define NMULT        4
`define NBANK        9
`define NSEL         4
`define SELW         2
`define SHIFTW       32
`define BANK_RST     18'h00000
`define SUM_RST      37'h0000000000
`define LOOP_MSB     35
`define LOOP_LSB     18

`endif

// *** common/dsp_half_pkg.sv ***
/*
 * types for the multiply half-block front end.
 * assumes dsp_half_defines.svh is available on the include path.
 */
package dsp_half_pkg;

    // operating mode of one half; gray coded along the usual order
    typedef enum logic [2:0] {
        MODE_IND9    = 3'b000,
        MODE_IND12   = 3'b001,
        MODE_IND18   = 3'b011,
        MODE_IND36   = 3'b010,
        MODE_DOUBLE  = 3'b110,
        MODE_SUM2    = 3'b111,
        MODE_SHIFT   = 3'b101
    } mode_t;

    // dynamic shift operation
    typedef enum logic [2:0] {
        SH_LSL = 3'b000,
        SH_LSR = 3'b001,
        SH_ASL = 3'b011,
        SH_ASR = 3'b010,
        SH_ROT = 3'b110
    } shift_op_t;

    // where the first-stage result goes next
    typedef enum logic [1:0] {
        DST_PIPE  = 2'b00,
        DST_ADD2  = 2'b01,
        DST_RSU   = 2'b11,
        DST_OUTRG = 2'b10
    } dest_t;

endpackage

// *** rtl/dsp_pair_mult.sv ***
/*
 * one two-multiplier adder unit: two signed-aware products and a
 * static add or subtract into a 37-bit result.
 * assumes operands already padded and sign flags already selected.
 */
`timescale 1ns/1ns
`include "dsp_half_defines.svh"
module dsp_pair_mult #(
    parameter bit SUBTRACT = 1'b0
) (
    input  wire logic [`OPW-1:0]   a0_i,
    input  wire logic [`OPW-1:0]   b0_i,
    input  wire logic [`OPW-1:0]   a1_i,
    input  wire logic [`OPW-1:0]   b1_i,
    input  wire logic              sign_a_i,
    input  wire logic              sign_b_i,
    output logic      [`PRODW-1:0] p0_o,
    output logic      [`PRODW-1:0] p1_o,
    output logic      [`SUMW-1:0]  sum_o
);

    // operand extended by one bit; sign bit copied only when signed
    function automatic logic signed [`OPW:0] ext(
        input logic [`OPW-1:0] v,
        input logic            s
    );
        ext = {s & v[`OPW-1], v};
    endfunction

    // full-width product; result signed if either side signed
    function automatic logic signed [`SUMW:0] mul(
        input logic [`OPW-1:0] a,
        input logic [`OPW-1:0] b,
        input logic            sa,
        input logic            sb
    );
        logic signed [2*`OPW+1:0] full;
        full = ext(a, sa) * ext(b, sb);
        mul = full[`SUMW:0];
    endfunction

    wire logic signed [`SUMW:0] prod0;
    wire logic signed [`SUMW:0] prod1;
    wire logic signed [`SUMW:0] total;

    // adder direction is static; no run-time add/sub control exists
    assign prod0 = mul(a0_i, b0_i, sign_a_i, sign_b_i);
    assign prod1 = mul(a1_i, b1_i, sign_a_i, sign_b_i);
    assign total = SUBTRACT ? prod0 - prod1 : prod0 + prod1;
    assign p0_o  = prod0[`PRODW-1:0];
    assign p1_o  = prod1[`PRODW-1:0];
    assign sum_o = total[`SUMW-1:0];

endmodule

// *** rtl/dsp_half_front.sv ***
/*
 * front end of one half of the multiply block: nine input banks,
 * cascade and loopback feeds, sign control, two pair units, shift mode.
 * assumes operands come from fabric logic synchronous to clk_sys_i;
 * enable/clear selection among four shared lines is done here; one clock.
 */
`timescale 1ns/1ns
`include "dsp_half_defines.svh"
module dsp_half_front
    import dsp_half_pkg::*;
#(
    parameter dsp_half_pkg::mode_t MODE     = dsp_half_pkg::MODE_IND18,
    parameter int                  OP_WIDTH = 18,
    parameter bit [`NMULT-1:0]     REG_A    = 4'hF,
    parameter bit [`NMULT-1:0]     REG_B    = 4'hF,
    parameter bit [`NMULT-1:0]     A_CASC   = 4'h0,
    parameter bit                  LOOPBACK = 1'b0,
    parameter bit                  REG_SIGN = 1'b1,
    parameter bit [1:0]            SUB_CFG  = 2'b00,
    parameter dsp_half_pkg::dest_t DEST     = dsp_half_pkg::DST_OUTRG,
    parameter bit [`SELW-1:0]      ENA_SEL  = 2'h0,
    parameter bit [`SELW-1:0]      CLR_SEL  = 2'h0
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rstn_i,
    input  wire logic                    ce_i,
    input  wire logic [`NSEL-1:0]        ena_i,
    input  wire logic [`NSEL-1:0]        aclr_i,
    input  wire logic [`NMULT*`OPW-1:0]  data_a_i,
    input  wire logic [`NMULT*`OPW-1:0]  data_b_i,
    input  wire logic                    sign_a_i,
    input  wire logic                    sign_b_i,
    input  wire logic [`OPW-1:0]         casc_in_i,
    input  wire logic [`PRODW-1:0]       loop_result_i,
    input  wire logic [`SHIFTW-1:0]      shift_data_i,
    input  wire logic [4:0]              shift_amt_i,
    input  wire dsp_half_pkg::shift_op_t shift_op_i,
    output logic      [`OPW-1:0]         casc_out_o,
    output logic      [`OPW-1:0]         delay_bank_o,
    output logic      [`NMULT*`PRODW-1:0] prod_o,
    output logic      [2*`SUMW-1:0]      sum_o,
    output logic      [`SHIFTW-1:0]      shift_o,
    output logic                         sign_res_o,
    output logic      [1:0]              dest_o
);
    import dsp_half_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // build-time checks on the configuration
    // everything but signs, shift controls, enables and clears is a parameter
    initial begin
        if (LOOPBACK && MODE != MODE_IND18 && MODE != MODE_SUM2)
            $error("loopback needs 18-bit width");
        if (A_CASC != 4'h0 && MODE != MODE_IND18 && MODE != MODE_SUM2)
            $error("cascade needs 18-bit width");
    end

    // native width picked from operand width; narrower ones padded
    localparam int NATW = (OP_WIDTH <= 9)  ? 9  :
                          (OP_WIDTH <= 12) ? 12 : 18;
    localparam int PADW = NATW - OP_WIDTH;

    ////////////////////////////////////////////////////////////////////
    // reset release and shared line selection
    logic rst_q1_r;
    logic rst_q2_r;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q1_r <= 1'b0;
            rst_q2_r <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_q2_r <= rst_q1_r;
        end
    end

    wire logic ena_sel; // one of four shared enables
    wire logic clr_sel; // one of four shared clears
    wire logic bank_rst_n;
    wire logic step;
    assign ena_sel    = ena_i[ENA_SEL];
    assign clr_sel    = aclr_i[CLR_SEL];
    // clear acts asynchronously like the device reset
    assign bank_rst_n = rst_q2_r & ~clr_sel;
    assign step       = ce_i & ena_sel;

    ////////////////////////////////////////////////////////////////////
    // operand padding: narrow data moved up, zeros in the low bits
    function automatic logic [`OPW-1:0] pad(input logic [`OPW-1:0] v);
        logic [`OPW-1:0] t;
        t = v << PADW;
        pad = t;
    endfunction

    logic [`OPW-1:0] a_bank_r [`NMULT];
    logic [`OPW-1:0] b_bank_r [`NMULT];
    logic [`OPW-1:0] dly_bank_r;
    logic            sa_r;
    logic            sb_r;
    logic [`OPW-1:0] a_src [`NMULT];
    logic [`OPW-1:0] a_op  [`NMULT];
    logic [`OPW-1:0] b_src [`NMULT];
    logic [`OPW-1:0] b_op  [`NMULT];

    // A source: routing or the cascade chain, chosen at build time
    // b source: first multiplier may take the loopback word instead
    genvar gi;
    generate
        for (gi = 0; gi < `NMULT; gi++) begin : g_src
            if (A_CASC[gi]) begin : g_casc
                if (gi == 0) begin : g_first
                    assign a_src[gi] = casc_in_i;
                end else begin : g_next
                    assign a_src[gi] = a_bank_r[gi-1];
                end
            end else begin : g_par
                assign a_src[gi] = pad(data_a_i[gi*`OPW +: `OPW]);
            end
            if (gi == 0 && LOOPBACK) begin : g_loop
                // upper 18 registered result bits, one loop per half
                assign b_src[gi] =
                    loop_result_i[`LOOP_MSB:`LOOP_LSB];
            end else begin : g_bpar
                assign b_src[gi] = pad(data_b_i[gi*`OPW +: `OPW]);
            end
            // cascade taps always pass the register, bypass breaks chain
            assign a_op[gi] = (REG_A[gi] || A_CASC[gi]) ?
                              a_bank_r[gi] : a_src[gi];
            assign b_op[gi] = REG_B[gi] ? b_bank_r[gi] : b_src[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // input register banks, rising edge, cleared at reset
    always_ff @(posedge clk_sys_i or negedge bank_rst_n) begin
        if (!bank_rst_n) begin
            for (int i = 0; i < `NMULT; i++) begin
                a_bank_r[i] <= `BANK_RST;
                b_bank_r[i] <= `BANK_RST;
            end
            dly_bank_r <= `BANK_RST;
            sa_r       <= 1'b0;
            sb_r       <= 1'b0;
        end else if (step) begin
            for (int i = 0; i < `NMULT; i++) begin
                a_bank_r[i] <= a_src[i];
                b_bank_r[i] <= b_src[i];
            end
            dly_bank_r <= a_bank_r[`NMULT-1];
            sa_r       <= sign_a_i;
            sb_r       <= sign_b_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // one sign pair per half, shared by all four multipliers
    wire logic sa_eff;
    wire logic sb_eff;
    assign sa_eff = REG_SIGN ? sa_r : sign_a_i;
    assign sb_eff = REG_SIGN ? sb_r : sign_b_i;

    // two pair units; four 18x18 multipliers per half
    logic [`PRODW-1:0] prod_w [`NMULT];
    logic [`SUMW-1:0]  sum_w  [2];
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pair
            dsp_pair_mult #(
                .SUBTRACT (SUB_CFG[gi])
            ) u_pair (
                .a0_i     (a_op[2*gi]),
                .b0_i     (b_op[2*gi]),
                .a1_i     (a_op[2*gi+1]),
                .b1_i     (b_op[2*gi+1]),
                .sign_a_i (sa_eff),
                .sign_b_i (sb_eff),
                .p0_o     (prod_w[2*gi]),
                .p1_o     (prod_w[2*gi+1]),
                .sum_o    (sum_w[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // dynamic shift on a 32-bit vector while configured in shift mode (MODE_SHIFT)
    logic [2*`SHIFTW-1:0] rot_w;
    logic [`SHIFTW-1:0]   shift_nxt;
    assign rot_w = {shift_data_i, shift_data_i} << shift_amt_i;
    always_comb begin
        case (shift_op_i)
            SH_LSL:  shift_nxt = shift_data_i << shift_amt_i;
            SH_LSR:  shift_nxt = shift_data_i >> shift_amt_i;
            SH_ASL:  shift_nxt = shift_data_i <<< shift_amt_i;
            SH_ASR:  shift_nxt = $unsigned($signed(shift_data_i)
                                 >>> shift_amt_i);
            SH_ROT:  shift_nxt = rot_w[2*`SHIFTW-1:`SHIFTW];
            default: shift_nxt = shift_data_i;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // shift and sign outputs from flip-flops; this half's mode is its own
    logic [`SHIFTW-1:0] shift_r;
    logic               sign_res_r;
    always_ff @(posedge clk_sys_i or negedge rst_q2_r) begin
        if (!rst_q2_r) begin
            shift_r    <= '0;
            sign_res_r <= 1'b0;
        end else if (ce_i) begin
            shift_r    <= (MODE == MODE_SHIFT) ? shift_nxt : '0;
            sign_res_r <= sa_eff | sb_eff;
        end
    end

    // products and sums go on to later stages; they are combinational
    // here because the pipeline registers live downstream
    generate
        for (gi = 0; gi < `NMULT; gi++) begin : g_out
            assign prod_o[gi*`PRODW +: `PRODW] = prod_w[gi];
        end
    endgenerate
    assign sum_o        = {sum_w[1], sum_w[0]};
    assign casc_out_o   = a_bank_r[`NMULT-1];
    assign delay_bank_o = dly_bank_r;
    assign shift_o      = shift_r;
    assign sign_res_o   = sign_res_r;
    assign dest_o       = DEST;

    ////////////////////////////////////////////////////////////////////
    // checks
    AST_CASC_SHIFT: assert property (@(posedge clk_sys_i)
        disable iff (!bank_rst_n)
        (step && A_CASC[1]) |=> a_bank_r[1] == $past(a_bank_r[0]))
        else $error("cascade tap did not shift");
    AST_DELAY_BANK: assert property (@(posedge clk_sys_i)
        disable iff (!bank_rst_n)
        step |=> dly_bank_r == $past(a_bank_r[`NMULT-1]))
        else $error("delay bank lost word");
    AST_SIGN_RES: assert property (@(posedge clk_sys_i)
        disable iff (!rst_q2_r)
        (ce_i && !sa_eff && !sb_eff) |=> !sign_res_r)
        else $error("unsigned pair reported signed");
    AST_SIGN_REG: assert property (@(posedge clk_sys_i)
        disable iff (!bank_rst_n)
        step |=> (sa_r == $past(sign_a_i)) && (sb_r == $past(sign_b_i)))
        else $error("sign register missed update");
    AST_HOLD: assert property (@(posedge clk_sys_i)
        disable iff (!bank_rst_n)
        !step |=> $stable(a_bank_r[0]) && $stable(b_bank_r[0]))
        else $error("bank moved without enable");
    AST_CLEAR: assert property (@(posedge clk_sys_i)
        !bank_rst_n |-> a_bank_r[0] == `BANK_RST)
        else $error("bank not cleared");
    AST_LOOP: assert property (@(posedge clk_sys_i)
        disable iff (!bank_rst_n)
        (LOOPBACK && step) |=>
        b_bank_r[0] == $past(loop_result_i[`LOOP_MSB:`LOOP_LSB]))
        else $error("loopback word not taken");
    AST_SUM: assert property (@(posedge clk_sys_i)
        disable iff (!rst_q2_r)
        (!sa_eff && !sb_eff && !SUB_CFG[0]) |->
        sum_w[0] == {1'b0, prod_w[0]} + {1'b0, prod_w[1]})
        else $error("unsigned pair sum wrong");
    AST_SHIFT: assert property (@(posedge clk_sys_i)
        disable iff (!rst_q2_r)
        (MODE == MODE_SHIFT && ce_i && shift_op_i == SH_LSL) |=>
        shift_r == ($past(shift_data_i) << $past(shift_amt_i)))
        else $error("logical shift wrong");

endmodule

// *** testbench/fabric_feed.sv ***
/*
 * fabric side model: launch flops that feed operands and sign flags
 * into one half, plus the downstream result register for loopback.
 * assumes the bench drives its load inputs just after a rising edge.
 */
`timescale 1ns/1ns
module fabric_feed (
    input  wire logic        clk_sys_i,
    input  wire logic        ld_i,
    input  wire logic [71:0] a_i,
    input  wire logic [71:0] b_i,
    input  wire logic        sa_i,
    input  wire logic        sb_i,
    input  wire logic [73:0] sum_i,
    output logic      [71:0] data_a_o,
    output logic      [71:0] data_b_o,
    output logic             sign_a_o,
    output logic             sign_b_o,
    output logic      [35:0] loop_o
);
    ////////////////////////////////////////////////////////////////////
    // one sign pair serves all four operands, so a half never mixes
    always @(posedge clk_sys_i) begin
        if (ld_i) begin
            data_a_o <= a_i;
            data_b_o <= b_i;
            sign_a_o <= sa_i;
            sign_b_o <= sb_i;
        end
        loop_o <= sum_i[35:0]; // registered result, as downstream does
    end
endmodule

// *** testbench/dsp_half_block_input_mult_test.sv ***
/*
 * bench for one half front end: reset test, row table of operand
 * cases, then hold, clear, cascade and shift tests.
 * assumes the design package and the fabric model are compiled first.
 */
`timescale 1ns/1ns
module dsp_half_block_input_mult_test;
    import dsp_half_pkg::*;
    typedef struct packed {
        logic [17:0] a;
        logic [17:0] b;
        logic        sa;
        logic        sb;
    } row_t;
    logic         clk_sys_i = 1'b0;
    logic         rstn_i    = 1'b0;
    logic         ce_i      = 1'b1;
    logic [3:0]   ena_i     = 4'hF;
    logic [3:0]   aclr_i    = 4'h0;
    logic [71:0]  a_v       = {4{18'h15A5A}};
    logic [71:0]  b_v       = {4{18'h0F0F3}};
    logic         sa_v      = 1'b1;
    logic         sb_v      = 1'b0;
    logic [31:0]  sh_d      = 32'h00000000;
    logic [4:0]   sh_n      = 5'h00;
    shift_op_t    sh_op     = SH_LSL;
    logic [71:0]  data_a, data_b;
    logic         sign_a, sign_b, sres;
    logic [35:0]  loop_r;
    logic [17:0]  casc0, casc1, dly1;
    logic [143:0] prod;
    logic [143:0] prod_s;
    logic [73:0]  sum;
    logic [31:0]  shift0, shift1;
    logic [1:0]   dest;
    int           bad_count  = 0;
    int           num_checks = 0;
    int           cycles     = 0;
    // boundary values over every sign combination
    row_t rows [6] = '{'{18'h3FFFF, 18'h3FFFF, 1'b0, 1'b0},
        '{18'h20000, 18'h3FFFF, 1'b1, 1'b0},
        '{18'h1FFFF, 18'h20000, 1'b0, 1'b1},
        '{18'h20000, 18'h20000, 1'b1, 1'b1},
        '{18'h00003, 18'h3FFFE, 1'b1, 1'b1},
        '{18'h12345, 18'h0ABCD, 1'b0, 1'b0}};
    shift_op_t   ops [5]    = '{SH_LSL, SH_LSR, SH_ASL, SH_ASR, SH_ROT};
    logic [31:0] sh_exp [5] = '{32'h00000F10, 32'h0800000F,
        32'h00000F10, 32'hF800000F, 32'h00000F18};

    always #25 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////////////
    // fabric model, a plain half, a cascaded half and a shift half
    fabric_feed feed (.clk_sys_i(clk_sys_i), .ld_i(1'b1), .a_i(a_v),
        .b_i(b_v), .sa_i(sa_v), .sb_i(sb_v), .sum_i(sum),
        .data_a_o(data_a), .data_b_o(data_b), .sign_a_o(sign_a),
        .sign_b_o(sign_b), .loop_o(loop_r));
    dsp_half_front #(.SUB_CFG(2'b10), .DEST(DST_RSU)) dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .ena_i(ena_i), .aclr_i(aclr_i), .data_a_i(data_a),
        .data_b_i(data_b), .sign_a_i(sign_a), .sign_b_i(sign_b),
        .casc_in_i(18'h00000), .loop_result_i(loop_r),
        .shift_data_i(sh_d), .shift_amt_i(sh_n), .shift_op_i(sh_op),
        .casc_out_o(casc0), .delay_bank_o(), .prod_o(prod),
        .sum_o(sum), .shift_o(shift0), .sign_res_o(sres), .dest_o(dest));
    // cascaded half also loops the registered result into B0
    dsp_half_front #(.A_CASC(4'hF), .LOOPBACK(1'b1)) dut_c (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .ena_i(ena_i), .aclr_i(aclr_i), .data_a_i(data_a),
        .data_b_i(data_b), .sign_a_i(sign_a), .sign_b_i(sign_b),
        .casc_in_i(casc0), .loop_result_i(loop_r),
        .shift_data_i(sh_d), .shift_amt_i(sh_n), .shift_op_i(sh_op),
        .casc_out_o(casc1), .delay_bank_o(dly1), .prod_o(),
        .sum_o(), .shift_o(), .sign_res_o(), .dest_o());
    // shift half bypasses A operand and sign registers; B stays registered
    dsp_half_front #(.MODE(MODE_SHIFT), .REG_A(4'h0),
        .REG_SIGN(1'b0)) dut_s (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .ena_i(ena_i), .aclr_i(aclr_i), .data_a_i(data_a),
        .data_b_i(data_b), .sign_a_i(sign_a), .sign_b_i(sign_b),
        .casc_in_i(casc0), .loop_result_i(loop_r),
        .shift_data_i(sh_d), .shift_amt_i(sh_n), .shift_op_i(sh_op),
        .casc_out_o(), .delay_bank_o(), .prod_o(prod_s), .sum_o(),
        .shift_o(shift1), .sign_res_o(), .dest_o());

    ////////////////////////////////////////////////////////////////////
    // reference arithmetic: widen each operand by its own sign flag
    function automatic longint mul(logic [17:0] a, logic [17:0] b,
                                   logic sa, logic sb);
        longint x;
        longint y;
        x = sa ? longint'($signed(a)) : longint'({46'h0, a});
        y = sb ? longint'($signed(b)) : longint'({46'h0, b});
        return x * y;
    endfunction

    // returns {pair1, pair0, four products}; pair1 subtracts
    function automatic logic [217:0] expect_mult(logic [71:0] a,
        logic [71:0] b, logic sa, logic sb);
        longint       p [4];
        logic [143:0] pr;
        for (int k = 0; k < 4; k++) begin
            p[k] = mul(a[18*k+:18], b[18*k+:18], sa, sb);
            pr[36*k+:36] = p[k][35:0];
        end
        return {37'(p[2] - p[3]), 37'(p[0] + p[1]), pr};
    endfunction

    task automatic check(input logic [143:0] seen, input logic [143:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: %s mismatch", $time, what);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // hang guard: the whole run needs well under 400 cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            $display("Error at %0t: run timed out", $time);
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [217:0] e;
        logic [143:0] held;
        // live operands during reset must not reach the banks
        repeat (15) @(posedge clk_sys_i);
        #1;
        check(prod, 0, "product in reset");
        check(casc0, 0, "cascade in reset");
        check({sres, shift1}, 0, "sign and shift in reset");
        @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check(dest, DST_RSU, "destination");
        $display("test reset done");
        for (int r = 0; r < 6; r++) begin
            @(posedge clk_sys_i);
            for (int k = 0; k < 4; k++) begin
                a_v[18*k+:18] <= rows[r].a ^ 18'(k * 4660);
                b_v[18*k+:18] <= rows[r].b ^ 18'(k * 291);
            end
            sa_v <= rows[r].sa;
            sb_v <= rows[r].sb;
            repeat (2) @(posedge clk_sys_i);
            #1;
            e = expect_mult(a_v, b_v, sa_v, sb_v);
            check(prod, e[143:0], "product");
            check(sum, e[217:144], "pair result");
            check(prod_s, e[143:0], "bypassed product");
            repeat (2) @(posedge clk_sys_i);
            #1;
            check(sres, sa_v | sb_v, "result sign");
        end
        $display("test rows done");
        // clock enable and unselected enable lines both hold the banks
        held = prod;
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        a_v <= ~a_v;
        repeat (3) @(posedge clk_sys_i);
        #1;
        check(prod, held, "clock enable hold");
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        ena_i <= 4'hE;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check(prod, held, "enable hold");
        @(posedge clk_sys_i);
        ena_i <= 4'h1;
        @(posedge clk_sys_i);
        #1;
        e = expect_mult(a_v, b_v, sa_v, sb_v);
        check(prod, e[143:0], "selected enable");
        $display("test hold done");
        // only the selected clear line empties the banks, at once
        @(posedge clk_sys_i);
        aclr_i <= 4'hE;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check(prod, e[143:0], "unselected clear");
        @(posedge clk_sys_i);
        aclr_i <= 4'h1;
        #5;
        check(prod, 0, "async clear");
        @(posedge clk_sys_i);
        aclr_i <= 4'h0;
        a_v <= 72'h0;
        repeat (8) @(posedge clk_sys_i);
        $display("test clear done");
        // a word walks four taps of the next half, then the delay bank
        a_v[71:54] <= 18'h2AAAA;
        for (int i = 0; i < 6 && casc0 !== 18'h2AAAA; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        check(casc0, 18'h2AAAA, "cascade source");
        repeat (3) @(posedge clk_sys_i);
        #1;
        check(casc1, 0, "cascade early");
        @(posedge clk_sys_i);
        #1;
        check(casc1, 18'h2AAAA, "cascade tap four");
        @(posedge clk_sys_i);
        #1;
        check(dly1, 18'h2AAAA, "delay bank");
        $display("test cascade done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_i);
            sh_op <= ops[i];
            sh_d <= 32'h800000F1;
            sh_n <= 5'h04;
            @(posedge clk_sys_i);
            #1;
            check(shift1, sh_exp[i], "shift result");
            check(shift0, 0, "shift outside shift mode");
        end
        $display("test shift done");
        summarize();
    end
endmodule
